// *** hdl/tts_pkg.sv ***
package tts_pkg;
  localparam logic [7:0] ADDR_PIN_CFG   = 8'h01;
  localparam logic [7:0] ADDR_LOOP_TOL  = 8'h02;
  localparam logic [7:0] ADDR_BUSY_THR  = 8'h03;
  localparam logic [7:0] ADDR_MIX_PUMP  = 8'h24;
  localparam logic [7:0] ADDR_CONV      = 8'h25;
  localparam logic [7:0] ADDR_GAIN_CPL  = 8'h26;
  localparam logic [7:0] ADDR_GAIN_STG  = 8'h27;
  localparam logic [7:0] ADDR_STATE     = 8'h40;
  localparam logic [7:0] ADDR_RST_STATE = 8'h41;
  localparam int B_PUMP_OFF = 7;
  localparam int B_PUMP_SRC = 6;
  localparam int B_PUMP_SNK = 5;
  localparam int B_MIX_POL  = 3;
  localparam int B_MIX_ON   = 2;
  localparam int B_FILT_INJ = 1;
  localparam int B_CONV_INJ = 0;
  localparam int B_FCMP     = 7;
  localparam int B_JITTER   = 6;
  localparam int B_EXPORT   = 5;
  localparam int B_CHOP     = 4;
  localparam int B_SHAPE    = 3;
  localparam int B_CMROT    = 2;
  localparam int B_SPIN     = 0;
  localparam int B_GMAN     = 3;
  localparam int B_CPL1     = 2;
  localparam int B_CPL2     = 0;
  localparam int B_STG1     = 4;
  localparam int B_STG2     = 2;
  localparam int B_STG3     = 0;
  localparam int B_SLEEP    = 3;
  localparam int B_CAL      = 7;
  localparam int B_PLF      = 6;
  localparam int B_NOW      = 5;
  localparam int B_FILT     = 4;
  localparam int B_BUSY     = 3;
  localparam logic [7:0] RST_MIX_PUMP = 8'h00;
  localparam logic [7:0] RST_CONV     = 8'h40;
  localparam logic [7:0] RST_GAIN_CPL = 8'h00;
  localparam logic [7:0] RST_GAIN_STG = 8'h00;
  localparam logic [3:0] RST_PIN_CFG  = 4'h0;
  localparam logic [1:0] RST_LOOP_TOL = 2'h0;
  localparam logic [6:0] RST_BUSY_THR = 7'h00;
  localparam logic [7:0] MASK_GAIN_CPL = 8'h0F;
  localparam logic [7:0] MASK_GAIN_STG = 8'h3F;
  localparam logic [1:0] SPIN_HOLD = 2'h2;
  typedef enum logic [3:0] {
    SP_00 = 4'b0001,
    SP_01 = 4'b0010,
    SP_10 = 4'b0100,
    SP_11 = 4'b1000
  } tts_spin_t;
endpackage : tts_pkg

// *** hdl/tts_regs.sv ***
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module tts_regs
  import tts_pkg::*;
#(
  parameter int LOCK_FILT_BASE = 4
) (
  // Clock and reset.
  input  wire  logic       clk_sys,
  input  wire  logic       rst,
  // Register port.
  input  wire  logic [7:0] addr,
  input  wire  logic [7:0] wr_data,
  input  wire  logic       wr_en,
  input  wire  logic       rd_en,
  output var   logic [7:0] rd_data,
  // Synthesizer and receiver state.
  input  wire  logic       cal_start,
  input  wire  logic       cal_done,
  input  wire  logic       seq_start,
  input  wire  logic       seq_lock_fail,
  input  wire  logic       lock_now_in,
  input  wire  logic [6:0] rssi_level,
  input  wire  logic [7:0] sub_reset_done,
  // Pin levels and normal pin sources.
  input  wire  logic       lock_pin_level,
  input  wire  logic       data_clock_pin_pin_level,
  input  wire  logic       dio_pin_level,
  input  wire  logic       lock_normal,
  input  wire  logic       data_clock_pin_normal,
  input  wire  logic       dio_normal,
  // Converter samples.
  input  wire  logic       conv_sample_tick,
  input  wire  logic [1:0] conv_sample_bits,
  input  wire  logic       conv_sample_clk,
  // Automatic gain settings.
  input  wire  logic       auto_coupler_one,
  input  wire  logic [1:0] auto_coupler_two,
  input  wire  logic [5:0] auto_stage_gain,
  // Charge pump and mixer controls.
  output var   logic       pump_normal_off,
  output var   logic       pump_force_source,
  output var   logic       pump_force_sink,
  output var   logic       mixer_dc_drive_on,
  output var   logic       mixer_i_positive,
  output var   logic       mixer_q_positive,
  // Analog test module.
  output var   logic       filter_test_inject,
  output var   logic       converter_test_inject,
  output var   logic       analog_test_sleep,
  output var   logic [2:0] analog_test_select,
  // Converter controls.
  output var   logic       freq_comparator_out_on,
  output var   logic       sigma_delta_jitter_on,
  output var   logic       integrator_chop_off,
  output var   logic       mismatch_shaping_off,
  output var   logic       common_mode_rotation_off,
  output var   logic [1:0] converter_spin_pos,
  // Pin drive.
  output var   logic       lock_pin_out,
  output var   logic       data_clock_pin_pin_out,
  output var   logic       dio_pin_out,
  // Applied gains.
  output var   logic       gain_amp_manual,
  output var   logic       coupler_one_gain,
  output var   logic [1:0] coupler_two_gain,
  output var   logic [1:0] stage_one_gain,
  output var   logic [1:0] stage_two_gain,
  output var   logic [1:0] stage_three_gain
);

  if (LOCK_FILT_BASE < 1 || LOCK_FILT_BASE > 31) begin : g_bad_base
    $error("LOCK_FILT_BASE must lie in 1 to 31");
  end

  localparam logic [7:0] FILT_BASE = 8'(LOCK_FILT_BASE);

  // Filtered lock needs a run of instant lock that doubles per tolerance step.
  function automatic logic [7:0] lock_run(input logic [1:0] tol);
    lock_run = FILT_BASE << tol;
  endfunction : lock_run

  function automatic logic [1:0] spin_code(input tts_spin_t s);
    case (s)
      SP_01:   spin_code = 2'h1;
      SP_10:   spin_code = 2'h2;
      SP_11:   spin_code = 2'h3;
      default: spin_code = 2'h0;
    endcase
  endfunction : spin_code

  logic [7:0] mix_pump_q;
  logic [7:0] conv_q;
  logic [7:0] gain_cpl_q;
  logic [7:0] gain_stg_q;
  logic [3:0] pin_cfg_q;
  logic [1:0] loop_tol_q;
  logic [6:0] busy_thr_q;
  logic       cal_fin_q;
  logic       plf_q;
  logic       now_q;
  logic       filt_q;
  logic       busy_q;
  logic [2:0] pins_q;
  logic [7:0] rst_state_q;
  logic [7:0] lock_cnt_q;
  logic [7:0] lock_cnt_d;
  tts_spin_t  spin_q;
  tts_spin_t  spin_d;

  // Address decode.
  wire w_mix  = wr_en && (addr == ADDR_MIX_PUMP);
  wire w_conv = wr_en && (addr == ADDR_CONV);
  wire w_cpl  = wr_en && (addr == ADDR_GAIN_CPL);
  wire w_stg  = wr_en && (addr == ADDR_GAIN_STG);
  wire w_pin  = wr_en && (addr == ADDR_PIN_CFG);
  wire w_tol  = wr_en && (addr == ADDR_LOOP_TOL);
  wire w_thr  = wr_en && (addr == ADDR_BUSY_THR);

  // Status readout.
  wire [7:0] state_word = {cal_fin_q, plf_q, now_q, filt_q, busy_q, pins_q};

  logic [7:0] rd_mux;
  always_comb begin
    if (addr == ADDR_MIX_PUMP) begin
      rd_mux = mix_pump_q;
    end else if (addr == ADDR_CONV) begin
      rd_mux = conv_q;
    end else if (addr == ADDR_GAIN_CPL) begin
      rd_mux = gain_cpl_q;
    end else if (addr == ADDR_GAIN_STG) begin
      rd_mux = gain_stg_q;
    end else if (addr == ADDR_PIN_CFG) begin
      rd_mux = {4'h0, pin_cfg_q};
    end else if (addr == ADDR_LOOP_TOL) begin
      rd_mux = {6'h00, loop_tol_q};
    end else if (addr == ADDR_BUSY_THR) begin
      rd_mux = {1'b0, busy_thr_q};
    end else if (addr == ADDR_STATE) begin
      rd_mux = state_word;
    end else if (addr == ADDR_RST_STATE) begin
      rd_mux = rst_state_q;
    end else begin
      rd_mux = 8'h00;
    end
  end

  // Control registers. Status addresses have no write decode at all.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mix_pump_q <= RST_MIX_PUMP;
      conv_q     <= RST_CONV;
      gain_cpl_q <= RST_GAIN_CPL;
      gain_stg_q <= RST_GAIN_STG;
      pin_cfg_q  <= RST_PIN_CFG;
      loop_tol_q <= RST_LOOP_TOL;
      busy_thr_q <= RST_BUSY_THR;
    end else begin
      if (w_mix) mix_pump_q <= wr_data;
      if (w_conv) conv_q <= wr_data;
      // Reserved bits are dropped so they always read zero.
      if (w_cpl) gain_cpl_q <= wr_data & MASK_GAIN_CPL;
      if (w_stg) gain_stg_q <= wr_data & MASK_GAIN_STG;
      if (w_pin) pin_cfg_q <= wr_data[3:0];
      if (w_tol) loop_tol_q <= wr_data[1:0];
      if (w_thr) busy_thr_q <= wr_data[6:0];
    end
  end

  // Read data stand only in the cycle after the strobe.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= rd_en ? rd_mux : 8'h00;
    end
  end

  // Filtered lock: a run counter that saturates once the run is long enough.
  wire [7:0] run_len = lock_run(loop_tol_q);
  wire       run_ok  = lock_cnt_q >= run_len;
  always_comb begin
    if (!lock_now_in) begin
      lock_cnt_d = 8'h00;
    end else if (run_ok) begin
      lock_cnt_d = lock_cnt_q;
    end else begin
      lock_cnt_d = lock_cnt_q + 8'h01;
    end
  end

  // Event flags. Where set and clear meet in one cycle the set wins.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cal_fin_q   <= 1'b0;
      plf_q       <= 1'b0;
      now_q       <= 1'b0;
      filt_q      <= 1'b0;
      busy_q      <= 1'b0;
      pins_q      <= 3'h0;
      rst_state_q <= 8'h00;
      lock_cnt_q  <= 8'h00;
    end else begin
      if (cal_done) begin
        cal_fin_q <= 1'b1;
      end else if (cal_start) begin
        cal_fin_q <= 1'b0;
      end
      if (seq_lock_fail) begin
        plf_q <= 1'b1;
      end else if (seq_start) begin
        plf_q <= 1'b0;
      end
      now_q       <= lock_now_in;
      lock_cnt_q  <= lock_cnt_d;
      filt_q      <= lock_now_in && run_ok;
      busy_q      <= rssi_level > busy_thr_q;
      pins_q      <= {lock_pin_level, data_clock_pin_pin_level, dio_pin_level};
      rst_state_q <= sub_reset_done;
    end
  end

  // Input rotation order for the converter, stepped once per sample.
  // A mode change part way through a sequence carries on from the current position,
  // so software that needs a clean start parks the sequencer with the hold code first.
  wire [1:0] spin_mode = conv_q[B_SPIN+:2];
  always_comb begin
    spin_d = spin_q;
    if (spin_mode == SPIN_HOLD) begin
      spin_d = SP_00;
    end else if (conv_sample_tick) begin
      case (spin_q)
        SP_00:   spin_d = (spin_mode == 2'h0) ? SP_01 : SP_10;
        SP_01:   spin_d = (spin_mode == 2'h0) ? SP_10 : SP_00;
        SP_10:   spin_d = (spin_mode == 2'h3) ? SP_00 : SP_11;
        SP_11:   spin_d = (spin_mode == 2'h0) ? SP_00 : SP_01;
        default: spin_d = SP_00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      spin_q <= SP_00;
    end else begin
      spin_q <= spin_d;
    end
  end

  // Derived controls.
  wire inj      = mix_pump_q[B_FILT_INJ] | mix_pump_q[B_CONV_INJ];
  wire mix_on   = mix_pump_q[B_MIX_ON];
  wire exporting = conv_q[B_EXPORT];
  wire manual   = gain_cpl_q[B_GMAN];
  wire [2:0] sel_d = inj ? pin_cfg_q[2:0] : {1'b1, pin_cfg_q[1:0]};

  // All outputs are registered; each lags its register by one cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pump_normal_off          <= 1'b0;
      pump_force_source        <= 1'b0;
      pump_force_sink          <= 1'b0;
      mixer_dc_drive_on        <= 1'b0;
      mixer_i_positive         <= 1'b0;
      mixer_q_positive         <= 1'b0;
      filter_test_inject       <= 1'b0;
      converter_test_inject    <= 1'b0;
      analog_test_sleep        <= 1'b1;
      analog_test_select       <= 3'h4;
      freq_comparator_out_on   <= 1'b0;
      sigma_delta_jitter_on    <= 1'b1;
      integrator_chop_off      <= 1'b0;
      mismatch_shaping_off     <= 1'b0;
      common_mode_rotation_off <= 1'b0;
      converter_spin_pos       <= 2'h0;
      lock_pin_out             <= 1'b0;
      data_clock_pin_pin_out             <= 1'b0;
      dio_pin_out              <= 1'b0;
      gain_amp_manual          <= 1'b0;
      coupler_one_gain         <= 1'b0;
      coupler_two_gain         <= 2'h0;
      stage_one_gain           <= 2'h0;
      stage_two_gain           <= 2'h0;
      stage_three_gain         <= 2'h0;
    end else begin
      pump_normal_off          <= mix_pump_q[B_PUMP_OFF];
      pump_force_source        <= mix_pump_q[B_PUMP_SRC];
      pump_force_sink          <= mix_pump_q[B_PUMP_SNK];
      mixer_dc_drive_on        <= mix_on;
      mixer_i_positive         <= mix_on & mix_pump_q[B_MIX_POL+1];
      mixer_q_positive         <= mix_on & mix_pump_q[B_MIX_POL];
      filter_test_inject       <= mix_pump_q[B_FILT_INJ];
      converter_test_inject    <= mix_pump_q[B_CONV_INJ];
      analog_test_sleep        <= inj ? pin_cfg_q[B_SLEEP] : 1'b1;
      analog_test_select       <= sel_d;
      freq_comparator_out_on   <= conv_q[B_FCMP];
      sigma_delta_jitter_on    <= conv_q[B_JITTER];
      integrator_chop_off      <= conv_q[B_CHOP];
      mismatch_shaping_off     <= conv_q[B_SHAPE];
      common_mode_rotation_off <= conv_q[B_CMROT];
      converter_spin_pos       <= spin_code(spin_q);
      lock_pin_out             <= exporting ? conv_sample_bits[1] : lock_normal;
      data_clock_pin_pin_out             <= exporting ? conv_sample_clk : data_clock_pin_normal;
      dio_pin_out              <= exporting ? conv_sample_bits[0] : dio_normal;
      gain_amp_manual          <= manual;
      coupler_one_gain         <= manual ? gain_cpl_q[B_CPL1] : auto_coupler_one;
      coupler_two_gain         <= manual ? gain_cpl_q[B_CPL2+:2] : auto_coupler_two;
      stage_one_gain           <= manual ? gain_stg_q[B_STG1+:2] : auto_stage_gain[5:4];
      stage_two_gain           <= manual ? gain_stg_q[B_STG2+:2] : auto_stage_gain[3:2];
      stage_three_gain         <= manual ? gain_stg_q[B_STG3+:2] : auto_stage_gain[1:0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_pump_off_follow: assert property (w_mix |-> ##2 pump_normal_off == $past(wr_data[B_PUMP_OFF], 2))
    else $error("pump off output does not follow its bit");

  a_pump_force: assert property (w_mix ##1 !w_mix |=> pump_force_source == mix_pump_q[B_PUMP_SRC]
                                 && pump_force_sink == mix_pump_q[B_PUMP_SNK])
    else $error("pump force outputs wrong");

  a_mixer_sign: assert property ($past(mix_on) && !mix_on |-> mixer_dc_drive_on
                                 && mixer_i_positive == $past(mix_pump_q[B_MIX_POL+1]))
    else $error("mixer sign wrong");

  a_test_route: assert property (!inj ##1 !inj |-> analog_test_sleep && analog_test_select[2])
    else $error("test module not parked");

  a_calib_flag: assert property ((cal_done |=> cal_fin_q) and (cal_start && !cal_done |=> !cal_fin_q))
    else $error("calibration flag wrong");

  a_lock_fail: assert property ((seq_lock_fail |=> plf_q) and (plf_q && !seq_start |=> plf_q))
    else $error("lock failure flag not set");

  a_busy_flag: assert property (rssi_level > busy_thr_q ##1 !w_thr |-> busy_q)
    else $error("busy flag low above threshold");

  a_ro_write: assert property (wr_en && addr == ADDR_STATE |=> $stable(mix_pump_q) && $stable(conv_q)
                               && $stable(gain_cpl_q) && $stable(gain_stg_q))
    else $error("status write changed a register");

  a_spin_hold: assert property (spin_mode == SPIN_HOLD |=> spin_q == SP_00)
    else $error("spin not held at zero");

  a_filt_drop: assert property (!lock_now_in |=> !filt_q && lock_cnt_q == 8'h00)
    else $error("filtered lock survives loss");

  // Each output is compared with the write data two edges earlier, which is the register stage plus the fixed output lag.
  // A write lands on its register at the strobe edge and reaches the output one edge later.
  a_conv_follow: assert property (w_conv |-> ##2 integrator_chop_off == $past(wr_data[B_CHOP], 2))
    else $error("converter feature output does not follow its bit");

  a_fcmp_follow: assert property (w_conv |-> ##2 freq_comparator_out_on == $past(wr_data[B_FCMP], 2))
    else $error("comparator output does not follow its bit");

  a_pin_export: assert property (exporting |=> data_clock_pin_pin_out == $past(conv_sample_clk)
                                 && lock_pin_out == $past(conv_sample_bits[1]))
    else $error("converter samples not on pins");

  a_inj_route: assert property (inj |=> analog_test_sleep == $past(pin_cfg_q[B_SLEEP])
                                && analog_test_select == $past(pin_cfg_q[2:0]))
    else $error("test module not routed from pin config");

  a_gain_manual: assert property (manual |=> gain_amp_manual && coupler_one_gain == $past(gain_cpl_q[B_CPL1])
                                  && coupler_two_gain == $past(gain_cpl_q[B_CPL2+:2]))
    else $error("manual coupler gain not applied");

  a_stage_override: assert property (manual |=> stage_one_gain == $past(gain_stg_q[B_STG1+:2])
                                     && stage_three_gain == $past(gain_stg_q[B_STG3+:2]))
    else $error("manual stage gain not applied");

  a_busy_clear: assert property (rssi_level <= busy_thr_q |=> !busy_q)
    else $error("busy flag high at or below threshold");

  // The strict compare means a level equal to the threshold reads as idle.
  a_spin_pair: assert property (spin_mode == 2'h3 && conv_sample_tick && spin_q == SP_10 |=> spin_q == SP_00)
    else $error("alternating spin does not return to zero");

endmodule : tts_regs
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import tts_pkg::*;
;
  logic       clk_sys, rst, wr_en, rd_en, cal_start, cal_done, seq_start, seq_lock_fail, lock_now_in;
  logic [7:0] addr, wr_data, rd_data, sub_reset_done;
  logic [6:0] rssi_level;
  logic       lock_pin_level, data_clock_pin_pin_level, dio_pin_level, lock_normal, data_clock_pin_normal, dio_normal;
  logic       conv_sample_tick, conv_sample_clk, auto_coupler_one;
  logic [1:0] conv_sample_bits, auto_coupler_two;
  logic [5:0] auto_stage_gain;
  logic       pump_normal_off, pump_force_source, pump_force_sink, mixer_dc_drive_on;
  logic       mixer_i_positive, mixer_q_positive, filter_test_inject, converter_test_inject;
  logic       analog_test_sleep, freq_comparator_out_on, sigma_delta_jitter_on, integrator_chop_off;
  logic       mismatch_shaping_off, common_mode_rotation_off, lock_pin_out, data_clock_pin_pin_out, dio_pin_out;
  logic       gain_amp_manual, coupler_one_gain;
  logic [2:0] analog_test_select;
  logic [1:0] converter_spin_pos, coupler_two_gain, stage_one_gain, stage_two_gain, stage_three_gain;
  logic [7:0] got;
  logic [1:0] spin_exp [4][4];
  int         fail_count, n_tests;

  tts_regs #(.LOCK_FILT_BASE(4)) dut_u (.*);

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic final_report;
    if (fail_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  // Bounded by a generous multiple of the sequence length.
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end

  task automatic check_defaults;
    rd(ADDR_MIX_PUMP, got); chk(got, 8'h00);
    rd(ADDR_CONV, got);     chk(got, 8'h40);
    rd(ADDR_GAIN_CPL, got); chk(got, 8'h00);
    rd(ADDR_GAIN_STG, got); chk(got, 8'h00);
    rd(ADDR_BUSY_THR, got); chk(got, 8'h00);
    chk({4'h0, sigma_delta_jitter_on, analog_test_sleep, pump_normal_off, mixer_dc_drive_on}, 8'h0C);
    chk({5'h0, analog_test_select}, 8'h04);
  endtask : check_defaults

  initial begin
    {rst, wr_en, rd_en, cal_start, cal_done, seq_start, seq_lock_fail, lock_now_in} = 8'h80;
    {addr, wr_data, rssi_level, sub_reset_done} = '0;
    {lock_pin_level, data_clock_pin_pin_level, dio_pin_level, conv_sample_tick, conv_sample_clk} = '0;
    {lock_normal, data_clock_pin_normal, dio_normal} = 3'b100;
    conv_sample_bits = 2'b01;
    auto_coupler_one = 1'b0;
    auto_coupler_two = 2'h3;
    auto_stage_gain  = 6'h1B;
    fail_count = 0;
    n_tests    = 0;
    spin_exp = '{'{2'h1, 2'h2, 2'h3, 2'h0}, '{2'h2, 2'h3, 2'h1, 2'h0},
                 '{2'h0, 2'h0, 2'h0, 2'h0}, '{2'h2, 2'h0, 2'h2, 2'h0}};
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    check_defaults();
    // Charge pump forcing and mixer drive.
    wr(ADDR_MIX_PUMP, 8'hE0); tick(2);
    chk({5'h0, pump_normal_off, pump_force_source, pump_force_sink}, 8'h07);
    wr(ADDR_MIX_PUMP, 8'h40); tick(2);
    chk({5'h0, pump_normal_off, pump_force_source, pump_force_sink}, 8'h02);
    wr(ADDR_MIX_PUMP, 8'h20); tick(2);
    chk({5'h0, pump_normal_off, pump_force_source, pump_force_sink}, 8'h01);
    wr(ADDR_MIX_PUMP, 8'h18); tick(2);
    chk({5'h0, mixer_dc_drive_on, mixer_i_positive, mixer_q_positive}, 8'h00);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_MIX_PUMP, 8'h04 | 8'(c << 3)); tick(2);
      chk({5'h0, mixer_dc_drive_on, mixer_i_positive, mixer_q_positive}, 8'h04 | 8'(c));
    end
    // Test module routing follows the full host pin configuration while injecting, only its select bits 1:0 otherwise.
    wr(ADDR_PIN_CFG, 8'h02); wr(ADDR_MIX_PUMP, 8'h00); tick(2);
    chk({4'h0, analog_test_sleep, analog_test_select}, 8'h0E);
    wr(ADDR_MIX_PUMP, 8'h02); tick(2);
    chk({2'h0, filter_test_inject, converter_test_inject, analog_test_sleep, analog_test_select}, 8'h22);
    wr(ADDR_PIN_CFG, 8'h0D); wr(ADDR_MIX_PUMP, 8'h01); tick(2);
    chk({2'h0, filter_test_inject, converter_test_inject, analog_test_sleep, analog_test_select}, 8'h1D);
    // Converter test bits and sample export.
    wr(ADDR_CONV, 8'h9C); tick(2);
    chk({3'h0, freq_comparator_out_on, sigma_delta_jitter_on, integrator_chop_off, mismatch_shaping_off,
         common_mode_rotation_off}, 8'h17);
    wr(ADDR_CONV, 8'h40); tick(2);
    chk({3'h0, freq_comparator_out_on, sigma_delta_jitter_on, integrator_chop_off, mismatch_shaping_off,
         common_mode_rotation_off}, 8'h08);
    chk({5'h0, lock_pin_out, data_clock_pin_pin_out, dio_pin_out}, 8'h04);
    conv_sample_clk <= 1'b1;
    wr(ADDR_CONV, 8'h20); tick(2);
    chk({5'h0, lock_pin_out, data_clock_pin_pin_out, dio_pin_out}, 8'h03);
    // Input rotation order for every spin code, each started from position 00.
    for (int m = 0; m < 4; m++) begin
      wr(ADDR_CONV, 8'h40 | 8'(SPIN_HOLD)); tick(2);
      chk({6'h0, converter_spin_pos}, 8'h00);
      wr(ADDR_CONV, 8'h40 | 8'(m));
      for (int k = 0; k < 4; k++) begin
        @(posedge clk_sys); conv_sample_tick <= 1'b1;
        @(posedge clk_sys); conv_sample_tick <= 1'b0;
        tick(2);
        chk({6'h0, converter_spin_pos}, {6'h0, spin_exp[m][k]});
      end
    end
    // Gain overrides; the unused upper bits are always written as zero.
    wr(ADDR_GAIN_STG, 8'h24);
    wr(ADDR_GAIN_CPL, 8'h05); tick(2);
    chk({gain_amp_manual, coupler_one_gain, coupler_two_gain, stage_one_gain, stage_two_gain}, 8'h36);
    chk({6'h0, stage_three_gain}, 8'h03);
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_GAIN_CPL, 8'h0C | 8'(c)); tick(2);
      chk({gain_amp_manual, coupler_one_gain, coupler_two_gain, stage_one_gain, stage_two_gain},
          8'hC9 | 8'(c << 4));
      chk({6'h0, stage_three_gain}, 8'h00);
    end
    rd(ADDR_GAIN_STG, got); chk(got, 8'h24);
    // Status flags.
    rd(ADDR_STATE, got); chk(got, 8'h00);
    @(posedge clk_sys); cal_done <= 1'b1; @(posedge clk_sys); cal_done <= 1'b0;
    tick(1); rd(ADDR_STATE, got); chk(got, 8'h80);
    @(posedge clk_sys); cal_start <= 1'b1; @(posedge clk_sys); cal_start <= 1'b0;
    tick(1); rd(ADDR_STATE, got); chk(got, 8'h00);
    @(posedge clk_sys); seq_lock_fail <= 1'b1; @(posedge clk_sys); seq_lock_fail <= 1'b0;
    tick(1); rd(ADDR_STATE, got); chk(got, 8'h40);
    @(posedge clk_sys); seq_start <= 1'b1; @(posedge clk_sys); seq_start <= 1'b0;
    tick(1); rd(ADDR_STATE, got); chk(got, 8'h00);
    for (int t = 0; t < 2; t++) begin
      wr(ADDR_LOOP_TOL, 8'(t)); tick(2);
      @(posedge clk_sys); lock_now_in <= 1'b1;
      rd(ADDR_STATE, got); chk(got, 8'h20);
      tick(12); rd(ADDR_STATE, got); chk(got, 8'h30);
      @(posedge clk_sys); lock_now_in <= 1'b0;
      tick(2); rd(ADDR_STATE, got); chk(got, 8'h00);
    end
    wr(ADDR_BUSY_THR, 8'h10);
    rssi_level <= 7'h10; tick(2); rd(ADDR_STATE, got); chk(got, 8'h00);
    rssi_level <= 7'h11; tick(2); rd(ADDR_STATE, got); chk(got, 8'h08);
    rssi_level <= 7'h00;
    for (int i = 0; i < 3; i++) begin
      {lock_pin_level, data_clock_pin_pin_level, dio_pin_level} <= 3'(1 << i);
      tick(2); rd(ADDR_STATE, got); chk(got, 8'(1 << i));
    end
    {lock_pin_level, data_clock_pin_pin_level, dio_pin_level} <= 3'b000;
    // Read-only and unmapped places.
    sub_reset_done <= 8'hA5;
    wr(ADDR_STATE, 8'hFF); tick(2); rd(ADDR_STATE, got); chk(got, 8'h00);
    rd(ADDR_MIX_PUMP, got); chk(got, 8'h01);
    rd(ADDR_RST_STATE, got); chk(got, 8'hA5);
    wr(ADDR_RST_STATE, 8'h00); tick(2); rd(ADDR_RST_STATE, got); chk(got, 8'hA5);
    wr(8'h7F, 8'hFF); rd(8'h7F, got); chk(got, 8'h00);
    // A reset in mid-run restores every default.
    wr(ADDR_MIX_PUMP, 8'hFF); wr(ADDR_CONV, 8'h00); wr(ADDR_GAIN_CPL, 8'h0F); wr(ADDR_PIN_CFG, 8'h00);
    @(posedge clk_sys); rst <= 1'b1;
    tick(2);
    @(posedge clk_sys); rst <= 1'b0;
    check_defaults();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
